/* File: common/uwis_defs.svh */
/*
  Register offsets, field positions, reset values and masks of the UART
  wake-up and interrupt status block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef UWIS_DEFS_SVH
`define UWIS_DEFS_SVH
`define UWIS_A_DAT 8'h00
`define UWIS_A_INTEN 8'h04
`define UWIS_A_FIFO 8'h08
`define UWIS_A_MODEM 8'h0c
`define UWIS_A_MODEMSTS 8'h10
`define UWIS_A_FIFOSTS 8'h14
`define UWIS_A_INTSTS 8'h18
`define UWIS_A_TOUT 8'h1c
`define UWIS_A_BAUD 8'h20
`define UWIS_A_ALTCTL 8'h2c
`define UWIS_A_FUNC_SEL 8'h30
`define UWIS_A_LINSTS 8'h34
`define UWIS_A_WKCTL 8'h40
`define UWIS_A_WKSTS 8'h44
`define UWIS_A_DWKCOMP 8'h48
`define UWIS_B_WAKE_IRQ_EN 6
`define UWIS_B_LIN_ANY 7
`define UWIS_B_TO_CNT_EN 11
`define UWIS_B_ATORTS 12
`define UWIS_B_ABRIEN 18
`define UWIS_B_TXIDLEEN 22
`define UWIS_B_TXIDLEIF 22
`define UWIS_B_TXIDLEINT 30
`define UWIS_B_ABRINT 31
`define UWIS_B_AB_ANY 17
`define UWIS_B_ADDR_DET_EN 15
`define UWIS_B_AUTO_ADDR 8
`define UWIS_B_RTS 1
`define UWIS_B_CTSLVL 4
`define UWIS_B_TXOVF 24
`define UWIS_INTEN_MASK 32'h004c18ff
`define UWIS_RST_FUNC_SEL 2'h0
`define UWIS_RST_LEVEL 4'h0
`define UWIS_RST_COMP 16'h0000
`define UWIS_RST_BAUD 16'h0000
`endif

/* File: common/uwis_pkg.sv */
/*
  Types shared by the UART wake-up and interrupt status block.
  Assumes nothing of its surroundings.
*/
package uwis_pkg;
  typedef enum logic [1:0] {
    UWIS_GAP_IDLE = 2'h0,
    UWIS_GAP_RUN = 2'h1
  } uwis_gap_st_t;
  typedef enum logic [1:0] {
    UWIS_FN_UART = 2'h0,
    UWIS_FN_LIN = 2'h1,
    UWIS_FN_IRDA = 2'h2,
    UWIS_FN_RS485 = 2'h3
  } uwis_func_t;
endpackage

/* File: logic/uwis_flag.sv */
/*
  Bank of sticky event flags, one per bit.
  Assumes single-cycle set and clear strobes on hclk.
*/
`timescale 1ns/1ps
module uwis_flag import uwis_pkg::*; #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flag_r
);
  genvar i;
  // Each flag is set by its event and cleared by software; the set wins.
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_r[i] <= 1'b0;
        end else if (ce) begin
          if (set[i]) begin
            flag_r[i] <= 1'b1;
          end else if (clr[i]) begin
            flag_r[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule

/* File: logic/uwis_txgap.sv */
/*
  Transmit gap timer: holds off the next start bit for a number of bit times.
  Assumes bit_tick pulses once per bit time and stop_done after each stop bit.
*/
`timescale 1ns/1ps
module uwis_txgap import uwis_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic bit_tick,
  input wire logic stop_done,
  input wire logic [7:0] gap,
  output logic tx_start_ok
);
  uwis_gap_st_t st_r;
  logic [7:0] cnt_r;

  // A gap starts after the last stop bit and ends after gap bit times.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= UWIS_GAP_IDLE;
      cnt_r <= 8'h00;
    end else if (ce) begin
      case (st_r)
        UWIS_GAP_IDLE: begin
          if (stop_done && gap != 8'h00) begin
            st_r <= UWIS_GAP_RUN;
            cnt_r <= gap;
          end
        end
        UWIS_GAP_RUN: begin
          if (bit_tick) begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              st_r <= UWIS_GAP_IDLE;
            end
          end
        end
        default: begin
          st_r <= UWIS_GAP_IDLE;
        end
      endcase
    end
  end

  // The transmitter may start a character only outside a gap.
  assign tx_start_ok = (st_r == UWIS_GAP_IDLE) && !(stop_done && gap != 8'h00);
endmodule

/* File: logic/uwis_top.sv */
/*
  UART wake-up, interrupt flag and status block with an AHB-Lite register
  slave. Assumes the rest of the UART supplies FIFO count, time-out count,
  address-byte result and one-cycle event pulses, all synchronous to hclk.
*/
// Behaviour
// - any wake flag raises the summary wake flag
// - wake interrupt needs summary flag and enable
// - power-down nCTS toggle sets clear-to-send wake
// - power-down receive toggle sets data wake
// - start sampling after start-compensation clock cycles
// - power-down FIFO count at trigger sets threshold wake
// - matching address byte in auto-address mode wakes
// - time-out count match below threshold wakes
// - interrupt asserts while flag and enable set
// - data register read clears receive flags
// - data register write clears transmit flags
// - line status is OR of four flags
// - modem status follows nCTS change flag
// - buffer error is OR of overflows
// - LIN flag needs writes to it and source
// - write one clears each wake flag
// - auto-baud flag is OR of two flags
// - function select zero gives plain UART mode
// - transmitter inserts programmable inter-character gap
// - hardware flow deasserts RTS at trigger level
`timescale 1ns/1ps
`include "uwis_defs.svh"
module uwis_top import uwis_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic power_down,
  input wire logic cts_n,
  input wire logic rxd,
  input wire logic [4:0] rx_fifo_count,
  input wire logic [7:0] rx_data,
  input wire logic [7:0] rx_timeout_count,
  input wire logic addr_byte_valid,
  input wire logic [7:0] addr_byte,
  input wire logic rx_avail_evt,
  input wire logic rx_timeout_evt,
  input wire logic tx_holding_empty_evt,
  input wire logic tx_idle_evt,
  input wire logic break_evt,
  input wire logic framing_evt,
  input wire logic parity_evt,
  input wire logic addr_detect_evt,
  input wire logic tx_overflow_evt,
  input wire logic rx_overflow_evt,
  input wire logic [4:0] lin_evt,
  input wire logic autobaud_done_evt,
  input wire logic autobaud_overflow_evt,
  input wire logic bit_tick,
  input wire logic tx_stop_done,
  output logic wake_request,
  output logic wake_irq_out,
  output logic [9:0] irq_out,
  output logic rts_n,
  output logic tx_start_ok,
  output logic rx_start_go,
  output logic [7:0] tx_data,
  output logic tx_data_we,
  output logic rx_data_re,
  output logic uart_mode,
  output logic [1:0] function_select,
  output logic [15:0] baud_divider,
  output logic rx_timeout_counter_enable
);
  // Flag bank indices.
  localparam int F_RXAV = 0;
  localparam int F_RXTO = 1;
  localparam int F_THRE = 2;
  localparam int F_TXID = 3;
  localparam int F_BRK = 4;
  localparam int F_FE = 5;
  localparam int F_PE = 6;
  localparam int F_ADT = 7;
  localparam int F_CTS = 8;
  localparam int F_TXOV = 9;
  localparam int F_RXOV = 10;
  localparam int F_LIN = 11;
  localparam int F_LANY = 16;
  localparam int F_WK = 17;
  localparam int F_ABD = 22;
  localparam int F_ABO = 23;
  localparam int NF = 24;

  logic [31:0] inten_r;
  logic [3:0] rx_trigger_level;
  logic [3:0] rts_trigger_level;
  logic modem_rts_r;
  logic [7:0] rx_timeout_value;
  logic [7:0] tx_gap_delay;
  logic [7:0] address_match_value;
  logic address_detect_enable;
  logic auto_address_detect_mode;
  logic [4:0] wake_enable_r;
  logic [15:0] start_bit_compensation;
  logic [NF-1:0] fset;
  logic [NF-1:0] fclr;
  logic [NF-1:0] flag;
  logic acc;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic wr_en;
  logic [31:0] rd_mux;
  logic cts_prev_r;
  logic rxd_prev_r;
  logic thr_prev_r;
  logic to_prev_r;
  logic thr_hit;
  logic to_hit;
  logic cts_tog;
  logic rxd_tog;
  logic [4:0] wake_set;
  logic [4:0] wake_flags;
  logic wake_any_flag;
  logic line_status_flag;
  logic buffer_error_flag;
  logic autobaud_any_flag;
  logic [7:0] int_flags;
  logic [15:0] comp_cnt_r;
  logic comp_busy_r;

  // Zero-wait slave: always ready, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && hready && htrans[1];

  // Address phase of a write is held for its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
    end else if (ce) begin
      wr_pend_r <= acc && hwrite;
      waddr_r <= haddr[7:0];
    end
  end
  assign wr_en = ce && wr_pend_r;

  // Read data is registered at the address phase; unmapped reads zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ce && acc && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // Data register strobes toward the FIFOs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data <= 8'h00;
      tx_data_we <= 1'b0;
      rx_data_re <= 1'b0;
    end else if (ce) begin
      tx_data_we <= wr_en && waddr_r == `UWIS_A_DAT;
      rx_data_re <= acc && !hwrite && haddr[7:0] == `UWIS_A_DAT;
      if (wr_en && waddr_r == `UWIS_A_DAT) begin
        tx_data <= hwdata[7:0];
      end
    end
  end

  // Control registers written by software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inten_r <= 32'h00000000;
      rx_trigger_level <= `UWIS_RST_LEVEL;
      rts_trigger_level <= `UWIS_RST_LEVEL;
      modem_rts_r <= 1'b0;
      rx_timeout_value <= 8'h00;
      tx_gap_delay <= 8'h00;
      baud_divider <= `UWIS_RST_BAUD;
      address_match_value <= 8'h00;
      address_detect_enable <= 1'b0;
      auto_address_detect_mode <= 1'b0;
      function_select <= `UWIS_RST_FUNC_SEL;
      wake_enable_r <= 5'h00;
      start_bit_compensation <= `UWIS_RST_COMP;
    end else if (wr_en) begin
      case (waddr_r)
        `UWIS_A_INTEN: inten_r <= hwdata & `UWIS_INTEN_MASK;
        `UWIS_A_FIFO: begin
          rx_trigger_level <= hwdata[7:4];
          rts_trigger_level <= hwdata[19:16];
        end
        `UWIS_A_MODEM: modem_rts_r <= hwdata[`UWIS_B_RTS];
        `UWIS_A_TOUT: begin
          rx_timeout_value <= hwdata[7:0];
          tx_gap_delay <= hwdata[15:8];
        end
        `UWIS_A_BAUD: baud_divider <= hwdata[15:0];
        `UWIS_A_ALTCTL: begin
          address_match_value <= hwdata[31:24];
          address_detect_enable <= hwdata[`UWIS_B_ADDR_DET_EN];
          auto_address_detect_mode <= hwdata[`UWIS_B_AUTO_ADDR];
        end
        `UWIS_A_FUNC_SEL: function_select <= hwdata[1:0];
        `UWIS_A_WKCTL: wake_enable_r <= hwdata[4:0];
        `UWIS_A_DWKCOMP: start_bit_compensation <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Previous pin and condition levels for toggle and edge detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_prev_r <= 1'b1;
      rxd_prev_r <= 1'b1;
      thr_prev_r <= 1'b0;
      to_prev_r <= 1'b0;
    end else if (ce) begin
      cts_prev_r <= cts_n;
      rxd_prev_r <= rxd;
      thr_prev_r <= thr_hit;
      to_prev_r <= to_hit;
    end
  end

  assign cts_tog = cts_n ^ cts_prev_r;
  assign rxd_tog = rxd ^ rxd_prev_r;
  assign thr_hit = rx_fifo_count >= {1'b0, rx_trigger_level};
  assign to_hit = rx_fifo_count < {1'b0, rx_trigger_level} &&
                  rx_timeout_count == rx_timeout_value;

  // Wake conditions, each only while the system is powered down.
  always_comb begin
    wake_set[0] = power_down && wake_enable_r[0] && cts_tog;
    wake_set[1] = power_down && wake_enable_r[1] && rxd_tog;
    wake_set[2] = power_down && wake_enable_r[2] && thr_hit && !thr_prev_r;
    wake_set[3] = power_down && wake_enable_r[2] && wake_enable_r[3] &&
                  function_select == UWIS_FN_RS485 && auto_address_detect_mode &&
                  address_detect_enable && addr_byte_valid && addr_byte == address_match_value;
    wake_set[4] = power_down && wake_enable_r[2] && wake_enable_r[4] &&
                  inten_r[`UWIS_B_TO_CNT_EN] && to_hit && !to_prev_r;
  end

  // After a data wake, count the compensation before sampling the start bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_cnt_r <= 16'h0000;
      comp_busy_r <= 1'b0;
      rx_start_go <= 1'b0;
    end else if (ce) begin
      rx_start_go <= 1'b0;
      if (wake_set[1] && !comp_busy_r) begin
        comp_cnt_r <= start_bit_compensation;
        comp_busy_r <= 1'b1;
      end else if (comp_busy_r) begin
        if (comp_cnt_r == 16'h0000) begin
          comp_busy_r <= 1'b0;
          rx_start_go <= 1'b1;
        end else begin
          comp_cnt_r <= comp_cnt_r - 16'h0001;
        end
      end
    end
  end

  // Event and clear strobes for every sticky flag.
  always_comb begin
    fset = '0;
    fclr = '0;
    fset[F_RXAV] = rx_avail_evt;
    fset[F_RXTO] = rx_timeout_evt;
    fset[F_THRE] = tx_holding_empty_evt;
    fset[F_TXID] = tx_idle_evt;
    fset[F_BRK] = break_evt;
    fset[F_FE] = framing_evt;
    fset[F_PE] = parity_evt;
    fset[F_ADT] = addr_detect_evt;
    fset[F_CTS] = cts_tog;
    fset[F_TXOV] = tx_overflow_evt;
    fset[F_RXOV] = rx_overflow_evt;
    fset[F_LIN +: 5] = lin_evt;
    fset[F_LANY] = |lin_evt;
    fset[F_WK +: 5] = wake_set;
    fset[F_ABD] = autobaud_done_evt;
    fset[F_ABO] = autobaud_overflow_evt;
    fclr[F_RXAV] = ce && acc && !hwrite && haddr[7:0] == `UWIS_A_DAT;
    fclr[F_RXTO] = fclr[F_RXAV];
    fclr[F_THRE] = wr_en && waddr_r == `UWIS_A_DAT;
    fclr[F_TXID] = fclr[F_THRE];
    if (wr_en && waddr_r == `UWIS_A_FIFOSTS) begin
      fclr[F_RXOV] = hwdata[0];
      fclr[F_ABD] = hwdata[1];
      fclr[F_ABO] = hwdata[2];
      fclr[F_ADT] = hwdata[3];
      fclr[F_PE] = hwdata[4];
      fclr[F_FE] = hwdata[5];
      fclr[F_BRK] = hwdata[6];
      fclr[F_TXOV] = hwdata[`UWIS_B_TXOVF];
    end
    if (wr_en && waddr_r == `UWIS_A_MODEMSTS) begin
      fclr[F_CTS] = hwdata[0];
    end
    if (wr_en && waddr_r == `UWIS_A_LINSTS) begin
      fclr[F_LIN +: 5] = hwdata[4:0];
    end
    // The summary LIN flag clears only once no source flag remains.
    if (wr_en && waddr_r == `UWIS_A_INTSTS) begin
      fclr[F_LANY] = hwdata[`UWIS_B_LIN_ANY] && ((flag[F_LIN +: 5] & ~fclr[F_LIN +: 5]) == 5'h00);
    end
    if (wr_en && waddr_r == `UWIS_A_WKSTS) begin
      fclr[F_WK +: 5] = hwdata[4:0];
    end
  end

  uwis_flag #(
    .W(NF)
  ) u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .set(fset),
    .clr(fclr),
    .flag_r(flag)
  );

  // Summary flags built from their sources.
  assign wake_flags = flag[F_WK +: 5];
  assign wake_any_flag = |wake_flags;
  assign line_status_flag = flag[F_BRK] | flag[F_FE] | flag[F_PE] | flag[F_ADT];
  assign buffer_error_flag = flag[F_TXOV] | flag[F_RXOV];
  assign autobaud_any_flag = flag[F_ABD] | flag[F_ABO];
  assign int_flags = {flag[F_LANY], wake_any_flag, buffer_error_flag, flag[F_RXTO],
                      flag[F_CTS], line_status_flag, flag[F_THRE], flag[F_RXAV]};

  // Interrupt outputs: flag gated by its enable.
  assign wake_irq_out = wake_any_flag && inten_r[`UWIS_B_WAKE_IRQ_EN];
  assign irq_out[7:0] = int_flags & inten_r[7:0];
  assign irq_out[8] = flag[F_TXID] && inten_r[`UWIS_B_TXIDLEEN];
  assign irq_out[9] = autobaud_any_flag && inten_r[`UWIS_B_ABRIEN];

  // Level wake request to the power controller.
  assign wake_request = |(wake_flags & wake_enable_r);

  // Flow control: auto mode releases RTS once the FIFO reaches its level.
  assign rts_n = inten_r[`UWIS_B_ATORTS] ?
                 (rx_fifo_count >= {1'b0, rts_trigger_level}) : !modem_rts_r;

  // Mode outputs to the rest of the UART.
  assign uart_mode = function_select == UWIS_FN_UART;
  assign rx_timeout_counter_enable = inten_r[`UWIS_B_TO_CNT_EN];

  uwis_txgap u_gap (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .bit_tick(bit_tick),
    .stop_done(tx_stop_done),
    .gap(tx_gap_delay),
    .tx_start_ok(tx_start_ok)
  );

  // Read multiplexer; reserved bits read zero.
  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `UWIS_A_DAT: rd_mux[7:0] = rx_data;
      `UWIS_A_INTEN: rd_mux = inten_r;
      `UWIS_A_FIFO: begin
        rd_mux[7:4] = rx_trigger_level;
        rd_mux[19:16] = rts_trigger_level;
      end
      `UWIS_A_MODEM: rd_mux[`UWIS_B_RTS] = modem_rts_r;
      `UWIS_A_MODEMSTS: begin
        rd_mux[0] = flag[F_CTS];
        rd_mux[`UWIS_B_CTSLVL] = cts_n;
      end
      `UWIS_A_FIFOSTS: begin
        rd_mux[6:0] = {flag[F_BRK], flag[F_FE], flag[F_PE], flag[F_ADT],
                       flag[F_ABO], flag[F_ABD], flag[F_RXOV]};
        rd_mux[`UWIS_B_TXOVF] = flag[F_TXOV];
      end
      `UWIS_A_INTSTS: begin
        rd_mux[7:0] = int_flags;
        rd_mux[15:8] = irq_out[7:0];
        rd_mux[`UWIS_B_TXIDLEIF] = flag[F_TXID];
        rd_mux[`UWIS_B_TXIDLEINT] = irq_out[8];
        rd_mux[`UWIS_B_ABRINT] = irq_out[9];
      end
      `UWIS_A_TOUT: rd_mux[15:0] = {tx_gap_delay, rx_timeout_value};
      `UWIS_A_BAUD: rd_mux[15:0] = baud_divider;
      `UWIS_A_ALTCTL: begin
        rd_mux[31:24] = address_match_value;
        rd_mux[`UWIS_B_AB_ANY] = autobaud_any_flag;
        rd_mux[`UWIS_B_ADDR_DET_EN] = address_detect_enable;
        rd_mux[`UWIS_B_AUTO_ADDR] = auto_address_detect_mode;
      end
      `UWIS_A_FUNC_SEL: rd_mux[1:0] = function_select;
      `UWIS_A_LINSTS: rd_mux[4:0] = flag[F_LIN +: 5];
      `UWIS_A_WKCTL: rd_mux[4:0] = wake_enable_r;
      `UWIS_A_WKSTS: rd_mux[4:0] = wake_flags;
      `UWIS_A_DWKCOMP: rd_mux[15:0] = start_bit_compensation;
      default: rd_mux = 32'h00000000;
    endcase
  end
endmodule

/* File: dv/uwis_sva.sv */
/*
  Checker for the UART wake-up and interrupt status block.
  Assumes it is bound into uwis_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "uwis_defs.svh"
module uwis_sva import uwis_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [9:0] irq_out,
  input wire logic wake_irq_out,
  input wire logic tx_start_ok,
  input wire logic tx_stop_done,
  input wire logic bit_tick,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_we,
  input wire logic rx_data_re,
  input wire logic uart_mode,
  input wire logic [1:0] function_select
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // An accepted address phase to one register offset.
  sequence s_ap(logic [7:0] a, logic w);
    hsel && hready && htrans[1] && ce && hwrite == w && haddr[7:0] == a;
  endsequence
  // The written byte lands on the transmit side after the data phase.
  sequence s_txw;
    tx_data_we && tx_data == $past(hwdata[7:0]);
  endsequence
  property p_mode;
    uart_mode == (function_select == 2'h0);
  endproperty
  property p_dat_rd;
    s_ap(`UWIS_A_DAT, 1'b0) |=> rx_data_re;
  endproperty
  property p_dat_wr;
    s_ap(`UWIS_A_DAT, 1'b1) |-> ##2 s_txw;
  endproperty
  property p_wake_irq;
    wake_irq_out == irq_out[6];
  endproperty
  property p_ists;
    s_ap(`UWIS_A_INTSTS, 1'b0) |=> (hrdata[15:8] & ~hrdata[7:0]) == 8'h00;
  endproperty
  property p_ists_wk;
    s_ap(`UWIS_A_INTSTS, 1'b0) |=> hrdata[14] == $past(wake_irq_out);
  endproperty
  property p_gap_dn;
    $fell(tx_start_ok) |-> tx_stop_done || $past(tx_stop_done);
  endproperty
  property p_gap_up;
    $rose(tx_start_ok) |-> bit_tick || $past(bit_tick);
  endproperty
  a_mode: assert property (p_mode) else $error("mode output wrong");
  a_dat_rd: assert property (p_dat_rd) else $error("no read strobe");
  a_dat_wr: assert property (p_dat_wr) else $error("no write strobe");
  a_wake_irq: assert property (p_wake_irq) else $error("wake irq mismatch");
  a_ists: assert property (p_ists) else $error("irq without flag");
  a_ists_wk: assert property (p_ists_wk) else $error("wake irq bit wrong");
  a_gap_dn: assert property (p_gap_dn) else $error("gap began unasked");
  a_gap_up: assert property (p_gap_up) else $error("gap ended off tick");
endmodule
bind uwis_top uwis_sva u_sva (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .irq_out(irq_out),
  .wake_irq_out(wake_irq_out), .tx_start_ok(tx_start_ok), .tx_stop_done(tx_stop_done), .bit_tick(bit_tick),
  .tx_data(tx_data), .tx_data_we(tx_data_we), .rx_data_re(rx_data_re), .uart_mode(uart_mode),
  .function_select(function_select));

/* File: dv/uwis_serial_peer.sv */
/*
  Far-side serial device model driving the clear-to-send and receive pins.
  Assumes one-cycle go pulses from the bench, synchronous to hclk.
*/
`timescale 1ns/1ps
module uwis_serial_peer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cts_go,
  input wire logic rx_go,
  input wire logic [3:0] lag,
  output logic cts_n,
  output logic rxd
);
  logic [3:0] cts_cnt_r;
  logic cts_arm_r;
  logic [3:0] rx_cnt_r;
  // Toggles clear-to-send after the asked lag, so answers come promptly or slowly.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_n <= 1'b1;
      cts_arm_r <= 1'b0;
      cts_cnt_r <= 4'h0;
    end else if (cts_go) begin
      cts_arm_r <= 1'b1;
      cts_cnt_r <= lag;
    end else if (cts_arm_r && cts_cnt_r == 4'h0) begin
      cts_n <= ~cts_n;
      cts_arm_r <= 1'b0;
    end else if (cts_arm_r) begin
      cts_cnt_r <= cts_cnt_r - 4'h1;
    end
  end
  // Sends an eight-cycle start bit; the line then returns to its idle high level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd <= 1'b1;
      rx_cnt_r <= 4'h0;
    end else if (rx_go) begin
      rxd <= 1'b0;
      rx_cnt_r <= 4'h8;
    end else if (rx_cnt_r != 4'h0) begin
      rx_cnt_r <= rx_cnt_r - 4'h1;
      rxd <= (rx_cnt_r == 4'h1);
    end
  end
endmodule

/* File: dv/uart_wakeup_and_interrupt_status_tb.sv */
/*
  Self-checking bench for the UART wake-up and interrupt status block.
  Assumes the design files, the package and the serial peer model are compiled first.
*/
`timescale 1ns/1ps
`include "uwis_defs.svh"
module uart_wakeup_and_interrupt_status_tb;
  logic hclk = 0, hresetn = 0, ce = 1, hsel = 1, hwrite = 0, power_down = 0, addr_byte_valid = 0;
  logic bit_tick = 0, tx_stop_done = 0, cts_go = 0, rx_go = 0, rd_ph = 0;
  logic [31:0] haddr = 0, hwdata = 0, p;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] rx_fifo_count = 0, lin_evt = 0;
  logic [7:0] rx_data = 8'h5a, rx_timeout_count = 0, addr_byte = 0, a;
  logic [11:0] ev = 0;
  logic [3:0] lag = 0, lv, g;
  logic [63:0] q[$];
  wire logic hready, hreadyout, hresp, cts_n, rxd, wake_request, wake_irq_out, rts_n, tx_start_ok;
  wire logic rx_start_go, tx_data_we, rx_data_re, uart_mode, rx_timeout_counter_enable;
  wire logic [31:0] hrdata;
  wire logic [9:0] irq_out;
  wire logic [7:0] tx_data;
  wire logic [1:0] function_select;
  wire logic [15:0] baud_divider;
  int err_total = 0, checked = 0, n, k, nn, v;
  int ei[8] = '{9, 10, 11, 7, 6, 5, 4, 8}, sb[8] = '{5, 17, 17, 2, 2, 2, 2, 5};
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  uwis_top u_dut (.rx_avail_evt(ev[0]), .rx_timeout_evt(ev[1]), .tx_holding_empty_evt(ev[2]),
    .tx_idle_evt(ev[3]), .break_evt(ev[4]), .framing_evt(ev[5]), .parity_evt(ev[6]), .addr_detect_evt(ev[7]),
    .tx_overflow_evt(ev[8]), .rx_overflow_evt(ev[9]), .autobaud_done_evt(ev[10]),
    .autobaud_overflow_evt(ev[11]), .*);
  uwis_serial_peer u_peer (.*);
  // Compares a seen value with an expected one and counts both outcomes.
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // An exhausted wait bound counts a mismatch and ends the run.
  task bnd(input int c, input int m);
    if (c >= m) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask
  task wt;
    int c;
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (hready !== 1'b1 && c < 20);
    bnd(c, 20);
  endtask
  task ap(input logic [7:0] ad, input logic w);
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    ap(ad, 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    cyc(1);
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    q.push_back({m, e & m});
    ap(ad, 1'b0);
    htrans <= 2'h0;
    rd_ph <= 1'b1;
    wt();
    rd_ph <= 1'b0;
  endtask
  task pev(input logic [16:0] e);
    {lin_evt, ev} <= e;
    cyc(1);
    {lin_evt, ev} <= 17'h0;
    cyc(2);
  endtask
  // Takes the oldest expected read off the queue when read data appears.
  always @(posedge hclk) begin
    if (rd_ph && q.size() > 0) begin
      chk(hrdata & q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h011f12cd));
    nn = $urandom_range(5, 12);
    lv = 4'($urandom_range(2, 15));
    g = 4'($urandom_range(1, 6));
    v = $urandom_range(1, 255);
    p = $urandom;
    cyc(3);
    hresetn <= 1'b1;
    cyc(1);
    rd(`UWIS_A_INTSTS, 0);
    rd(`UWIS_A_WKSTS, 0);
    rd(8'h3c, 0);
    for (k = 3; k >= 0; k--) begin
      wr(`UWIS_A_FUNC_SEL, k);
      rd(`UWIS_A_FUNC_SEL, k, 3);
    end
    wr(`UWIS_A_INTEN, 32'h004c18ff);
    wr(`UWIS_A_FIFO, {12'h0, lv, 8'h0, lv, 4'h0});
    rx_fifo_count <= 5'(lv - 1);
    cyc(2);
    chk(rts_n, 0);
    rx_fifo_count <= 5'(lv);
    cyc(2);
    chk(rts_n, 1);
    rx_fifo_count <= 0;
    power_down <= 1'b1;
    wr(`UWIS_A_WKCTL, 32'h1f);
    lag <= 4'($urandom_range(0, 9));
    cts_go <= 1'b1;
    cyc(1);
    cts_go <= 1'b0;
    cyc(14);
    rd(`UWIS_A_WKSTS, 1);
    rd(`UWIS_A_INTSTS, 32'h4848, 32'h4848);
    chk(wake_request, 1);
    wr(`UWIS_A_WKSTS, 1);
    wr(`UWIS_A_MODEMSTS, 1);
    rd(`UWIS_A_WKSTS, 0);
    rd(`UWIS_A_INTSTS, 0, 32'h4848);
    chk(wake_request, 0);
    wr(`UWIS_A_BAUD, nn + 8);
    chk(baud_divider, nn + 8);
    wr(`UWIS_A_DWKCOMP, nn);
    rx_go <= 1'b1;
    cyc(1);
    rx_go <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rxd !== 1'b0 && n < 50);
    bnd(n, 50);
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (rx_start_go !== 1'b1 && n < 99);
    chk(n, nn + 1);
    rd(`UWIS_A_WKSTS, 2);
    wr(`UWIS_A_WKSTS, 2);
    rx_fifo_count <= 5'(lv - 1);
    cyc(2);
    rd(`UWIS_A_WKSTS, 0);
    rx_fifo_count <= 5'(lv);
    cyc(2);
    rd(`UWIS_A_WKSTS, 4);
    wr(`UWIS_A_WKSTS, 4);
    rd(`UWIS_A_WKSTS, 0);
    wr(`UWIS_A_FUNC_SEL, 3);
    wr(`UWIS_A_ALTCTL, {p[7:0], 24'h008100});
    for (k = 0; k < 2; k++) begin
      addr_byte <= k ? p[7:0] : ~p[7:0];
      addr_byte_valid <= 1'b1;
      cyc(1);
      addr_byte_valid <= 1'b0;
      cyc(2);
      rd(`UWIS_A_WKSTS, k * 8);
    end
    wr(`UWIS_A_WKSTS, 8);
    wr(`UWIS_A_FUNC_SEL, 0);
    wr(`UWIS_A_TOUT, {16'h0, 4'h0, g, 8'(v)});
    rx_fifo_count <= 0;
    rx_timeout_count <= 8'(v);
    cyc(3);
    rd(`UWIS_A_WKSTS, 16);
    chk(rx_timeout_counter_enable, 1);
    wr(`UWIS_A_WKSTS, 16);
    power_down <= 1'b0;
    tx_stop_done <= 1'b1;
    cyc(1);
    tx_stop_done <= 1'b0;
    for (k = 0; k < g; k++) begin
      chk(tx_start_ok, 0);
      bit_tick <= 1'b1;
      cyc(1);
      bit_tick <= 1'b0;
      cyc(2);
    end
    chk(tx_start_ok, 1);
    pev(17'h3);
    rd(`UWIS_A_INTSTS, 32'h1111, 32'h1111);
    rd(`UWIS_A_DAT, {24'h0, rx_data});
    rd(`UWIS_A_INTSTS, 0, 32'h11);
    pev(17'hc);
    rd(`UWIS_A_INTSTS, 32'h00400002, 32'h00400002);
    wr(`UWIS_A_DAT, p);
    rd(`UWIS_A_INTSTS, 0, 32'h00400002);
    for (k = 0; k < 8; k++) begin
      a = (sb[k] == 17) ? `UWIS_A_ALTCTL : `UWIS_A_INTSTS;
      pev(17'(1) << ei[k]);
      rd(a, 32'(1) << sb[k], 32'(1) << sb[k]);
      wr(`UWIS_A_FIFOSTS, (k < 7) ? 32'(1) << k : 32'h01000000);
      rd(a, 0, 32'(1) << sb[k]);
    end
    for (k = 0; k < 5; k++) begin
      pev(17'(1) << (12 + k));
      wr(`UWIS_A_INTSTS, 32'h80);
      rd(`UWIS_A_INTSTS, 32'h80, 32'h80);
      wr(`UWIS_A_LINSTS, 32'(1) << k);
      wr(`UWIS_A_INTSTS, 32'h80);
      rd(`UWIS_A_INTSTS, 0, 32'h80);
    end
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    rd(`UWIS_A_INTEN, 0);
    cyc(2);
    tally_and_finish;
  end
endmodule
